// [hw/panel_button_lamp_control.sv]
// Module: operator panel button and lamp control with a Wishbone register slave
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`timescale 1ns/1ns
module panel_button_lamp_control #(
  parameter int NB        = panel_pkg::NUM_BUTTONS,
  parameter int NI        = panel_pkg::NUM_INDICATORS,
  parameter int BLINK_CYC = panel_pkg::BLINK_HALF_CYC
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // Wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [5:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Panel pins
  input  wire logic [NB-1:0] button_pin,
  output logic      [NB-1:0] button_lamp,
  output logic      [NI-1:0] indicator_lamp,
  output logic               irq
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam logic [NB-1:0] RST_BTN_W = '0;
  logic [NB-1:0] btn_meta_r;
  logic [NB-1:0] btn_sync_r;
  logic [NB-1:0] btn_prev_r;
  logic [NB-1:0] btn_rise;
  logic [NB-1:0] button_lamp_ctl_on_r;
  logic [NB-1:0] button_lamp_ctl_fl_r;
  logic          lamp_separation_r;
  logic [NB-1:0] button_latch_cfg_r;
  logic [NB-1:0] latch_state_r;
  logic [NB-1:0] latch_state_nxt;
  logic [NB-1:0] button_pressed_state;
  logic [NI-1:0] indicator_lamp_ctl_on_r;
  logic [NI-1:0] indicator_lamp_ctl_fl_r;
  logic [31:0]   blink_cnt_r;
  logic          blink_phase_r;
  logic [NB-1:0] irq_status_r;
  logic [NB-1:0] irq_enable_r;
  logic          wr_stb;
  logic          rd_stb;
  logic [NB-1:0] wr_btn;
  logic [NI-1:0] wr_ind;
  logic [NB-1:0] sep_mom;
  logic [NB-1:0] btn_lamp_nxt;
  logic [NI-1:0] ind_lamp_nxt;
  logic [NB-1:0] status_prev_r;
  logic [NB-1:0] status_change;
  logic [31:0]   rd_nxt;
  logic          blink_wrap;
  logic          btn_on_we;
  logic          btn_fl_we;
  logic          sep_we;
  logic          cfg_we;
  logic          ovr_set_we;
  logic          ovr_or_we;
  logic          ovr_nand_we;
  logic          ind_on_we;
  logic          ind_fl_we;
  logic          irq_en_we;
  logic          irq_clr_we;

  // Blink gating: lamp lit when on, dark during off phase when flashing
  function automatic logic lamp_out(input logic on, input logic fl, input logic phase);
    lamp_out = on & (~fl | phase);
  endfunction

  // Write strobe aimed at one register word
  function automatic logic wr_hit(input logic stb, input logic [5:0] adr,
                                  input logic [5:0] ofs);
    wr_hit = stb & (adr == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // One access per request; ack pulses for a single enabled cycle and holds while clk_en is low
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & clk_en
                & wb_sel_i[panel_pkg::DATA_LANE];
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o & clk_en;
  assign wr_btn = wb_dat_i[NB-1:0];
  assign wr_ind = wb_dat_i[NI-1:0];

  // Acknowledge every access, mapped or not, one cycle after it is seen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read data selection; write-only and unmapped words read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      panel_pkg::OFS_LAMP_SEP:   rd_nxt[panel_pkg::SEP_BIT] = lamp_separation_r;
      panel_pkg::OFS_BTN_STATUS: rd_nxt[NB-1:0] = button_pressed_state;
      panel_pkg::OFS_BTN_CFG:    rd_nxt[NB-1:0] = button_latch_cfg_r;
      panel_pkg::OFS_IRQ_STATUS: rd_nxt[NB-1:0] = irq_status_r;
      panel_pkg::OFS_IRQ_ENABLE: rd_nxt[NB-1:0] = irq_enable_r;
      default:                   rd_nxt         = 32'h0000_0000;
    endcase
  end

  // Read data register, loaded only when a read is taken, held until the next
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------------
  // One strobe per register word; each carries the clock enable and byte lane
  assign btn_on_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_BTN_LAMP_ON);
  assign btn_fl_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_BTN_LAMP_FL);
  assign sep_we      = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_LAMP_SEP);
  assign cfg_we      = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_BTN_CFG);
  assign ovr_set_we  = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_OVR_SET);
  assign ovr_or_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_OVR_OR);
  assign ovr_nand_we = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_OVR_NAND);
  assign ind_on_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_IND_ON);
  assign ind_fl_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_IND_FL);
  assign irq_en_we   = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_IRQ_ENABLE);
  assign irq_clr_we  = wr_hit(wr_stb, wb_adr_i, panel_pkg::OFS_IRQ_CLEAR);

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Button lamp-on bits are stored even when their preconditions fail
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      button_lamp_ctl_on_r <= panel_pkg::RST_BTN4;
    end else if (btn_on_we) begin
      button_lamp_ctl_on_r <= wr_btn;
    end
  end

  // Button flash bits, likewise stored whatever the mode
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      button_lamp_ctl_fl_r <= panel_pkg::RST_BTN4;
    end else if (btn_fl_we) begin
      button_lamp_ctl_fl_r <= wr_btn;
    end
  end

  // Separation enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lamp_separation_r <= panel_pkg::RST_BIT;
    end else if (sep_we) begin
      lamp_separation_r <= wb_dat_i[panel_pkg::SEP_BIT];
    end
  end

  // Per-button latch configuration, one selects alternate action
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      button_latch_cfg_r <= panel_pkg::RST_BTN4;
    end else if (cfg_we) begin
      button_latch_cfg_r <= wr_btn;
    end
  end

  // Indicator lamp on bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      indicator_lamp_ctl_on_r <= panel_pkg::RST_IND6;
    end else if (ind_on_we) begin
      indicator_lamp_ctl_on_r <= wr_ind;
    end
  end

  // Indicator lamp flash bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      indicator_lamp_ctl_fl_r <= panel_pkg::RST_IND6;
    end else if (ind_fl_we) begin
      indicator_lamp_ctl_fl_r <= wr_ind;
    end
  end

  // ---------------------------------------------------------------------------
  // Button input synchroniser
  // ---------------------------------------------------------------------------
  // Two flops before any logic sees the pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      btn_meta_r <= RST_BTN_W;
      btn_sync_r <= RST_BTN_W;
    end else if (clk_en) begin
      btn_meta_r <= button_pin;
      btn_sync_r <= btn_meta_r;
    end
  end

  // Previous synchronised level for press edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      btn_prev_r <= RST_BTN_W;
    end else if (clk_en) begin
      btn_prev_r <= btn_sync_r;
    end
  end

  // Rising press edge; reset value equals the idle pin level, so no false edge
  assign btn_rise = btn_sync_r & ~btn_prev_r;

  // ---------------------------------------------------------------------------
  // Latched state and overrides
  // ---------------------------------------------------------------------------
  // Overrides take priority over a press edge in the same cycle
  always_comb begin
    latch_state_nxt = latch_state_r ^ btn_rise;
    if (ovr_set_we) begin
      latch_state_nxt = wr_btn;
    end else if (ovr_or_we) begin
      latch_state_nxt = latch_state_r | wr_btn;
    end else if (ovr_nand_we) begin
      latch_state_nxt = ~(latch_state_r & wr_btn);
    end
  end

  // Only alternate-action buttons keep a latched state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      latch_state_r <= panel_pkg::RST_BTN4;
    end else if (clk_en) begin
      latch_state_r <= (latch_state_nxt & button_latch_cfg_r)
                     | (latch_state_r & ~button_latch_cfg_r);
    end
  end

  // Alternate reports the latch, momentary follows the pin
  assign button_pressed_state = (button_latch_cfg_r & latch_state_r)
                              | (~button_latch_cfg_r & btn_sync_r);

  // ---------------------------------------------------------------------------
  // Blink divider
  // ---------------------------------------------------------------------------
  // Shared phase toggles every BLINK_CYC cycles
  assign blink_wrap = (blink_cnt_r >= 32'(BLINK_CYC - 1));

  // Half-period counter, frozen with the clock enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blink_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (blink_wrap) begin
        blink_cnt_r <= 32'h0000_0000;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Phase flips at each counter wrap; every lamp shares it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      blink_phase_r <= 1'b0;
    end else if (clk_en && blink_wrap) begin
      blink_phase_r <= ~blink_phase_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Lamp outputs
  // ---------------------------------------------------------------------------
  // Separate control only for momentary buttons; otherwise lamp shows state
  assign sep_mom = {NB{lamp_separation_r}} & ~button_latch_cfg_r;

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      btn_lamp_nxt[i] = sep_mom[i]
        ? lamp_out(button_lamp_ctl_on_r[i], button_lamp_ctl_fl_r[i], blink_phase_r)
        : button_pressed_state[i];
    end
    for (int j = 0; j < NI; j++) begin
      ind_lamp_nxt[j] = lamp_out(indicator_lamp_ctl_on_r[j], indicator_lamp_ctl_fl_r[j],
                                 blink_phase_r);
    end
  end

  // Registered drivers for the four button lamps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      button_lamp <= panel_pkg::RST_BTN4;
    end else if (clk_en) begin
      button_lamp <= btn_lamp_nxt;
    end
  end

  // Registered drivers for the six indicator lamps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      indicator_lamp <= panel_pkg::RST_IND6;
    end else if (clk_en) begin
      indicator_lamp <= ind_lamp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  // A change of reported status is the interrupt event
  assign status_change = button_pressed_state ^ status_prev_r;

  // Reported status one cycle back
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_prev_r <= panel_pkg::RST_BTN4;
    end else if (clk_en) begin
      status_prev_r <= button_pressed_state;
    end
  end

  // Interrupt enable, one bit per button
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_enable_r <= panel_pkg::RST_BTN4;
    end else if (irq_en_we) begin
      irq_enable_r <= wr_btn;
    end
  end

  // Sticky change flags; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_status_r <= panel_pkg::RST_BTN4;
    end else if (clk_en) begin
      if (irq_clr_we) begin
        irq_status_r <= (irq_status_r & ~wr_btn) | status_change;
      end else begin
        irq_status_r <= irq_status_r | status_change;
      end
    end
  end

  // Level interrupt output
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status_r & irq_enable_r);
    end
  end

endmodule

// [hw/panel_pkg.sv]
// Package: register map, field widths and timing constants for the panel block
package panel_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int NUM_BUTTONS    = 4;
  localparam int NUM_INDICATORS = 6;

  // ---------------------------------------------------------------------------
  // Register byte offsets (word aligned)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OFS_BTN_LAMP_ON   = 6'h00;
  localparam logic [5:0] OFS_BTN_LAMP_FL   = 6'h04;
  localparam logic [5:0] OFS_LAMP_SEP      = 6'h08;
  localparam logic [5:0] OFS_BTN_STATUS    = 6'h0C;
  localparam logic [5:0] OFS_BTN_CFG       = 6'h10;
  localparam logic [5:0] OFS_OVR_SET       = 6'h14;
  localparam logic [5:0] OFS_OVR_OR        = 6'h18;
  localparam logic [5:0] OFS_OVR_NAND      = 6'h1C;
  localparam logic [5:0] OFS_IND_ON        = 6'h20;
  localparam logic [5:0] OFS_IND_FL        = 6'h24;
  localparam logic [5:0] OFS_IRQ_STATUS    = 6'h28;
  localparam logic [5:0] OFS_IRQ_ENABLE    = 6'h2C;
  localparam logic [5:0] OFS_IRQ_CLEAR     = 6'h30;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] RST_BTN4 = 4'h0;
  localparam logic [5:0] RST_IND6 = 6'h00;
  localparam logic       RST_BIT  = 1'b0;

  // ---------------------------------------------------------------------------
  // Field positions: all register data lives in byte lane 0
  // ---------------------------------------------------------------------------
  localparam int DATA_LANE = 0;
  localparam int SEP_BIT   = 0;

  // ---------------------------------------------------------------------------
  // Timing: blink half period in milliseconds, clock in Hz
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

endpackage

// [sim/panel_properties.sv]
// Checker: port-level properties of the panel control block
`timescale 1ns/1ns
module panel_properties #(
  parameter int NB = 4,
  parameter int NI = 6
) (
  input wire logic          mclk,
  input wire logic          sys_rst,
  input wire logic          clk_en,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [5:0]    wb_adr_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic [NB-1:0] button_pin,
  input wire logic [NB-1:0] button_lamp,
  input wire logic [NI-1:0] indicator_lamp,
  input wire logic          irq
);
  // ---------------------------------------------------------------------------
  // Bus, lamp and interrupt properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Request taken, and write strobes
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  wire logic wr  = req && wb_we_i && wb_sel_i[0];

  AST_ACK_PULSE: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_LAT: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_NO_SPUR: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_RST: assert property (disable iff (1'b0) sys_rst |=>
    (button_lamp == '0 && indicator_lamp == '0 && !irq && !wb_ack_o))
    else $error("outputs not cleared by reset");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_WO_READ0: assert property (req && !wb_we_i && (wb_adr_i == 6'h00
    || wb_adr_i == 6'h14 || wb_adr_i == 6'h3C) |=> wb_dat_o == 32'h0)
    else $error("write-only or unmapped read not zero");
  AST_IND_OFF: assert property (wr && wb_adr_i == 6'h20 && wb_dat_i[5:0] == 6'h00
    |-> ##[1:4] indicator_lamp == '0)
    else $error("indicator lamps stay lit after off write");
  AST_IRQ_MASK: assert property (wr && wb_adr_i == 6'h2C && wb_dat_i[3:0] == 4'h0
    |-> ##[1:4] !irq)
    else $error("irq stays high with all sources masked");

  // Main scenarios reached
  cover property (irq);
  cover property (indicator_lamp != '0);
  cover property (button_lamp != '0);
endmodule

// [sim/panel_buttons.sv]
// Model of the pushbuttons on the panel's far side
`timescale 1ns/1ns
module panel_buttons #(
  parameter int NB = 4
) (
  input  wire logic          mclk,
  output logic      [NB-1:0] button_pin
);
  // Released buttons read low from power-up
  initial button_pin = '0;
  // Press pattern changes just after an edge and holds until the next call
  task automatic press(input logic [NB-1:0] v);
    @(posedge mclk);
    button_pin <= v;
  endtask
endmodule

// [sim/tb_top.sv]
// Testbench: registers, lamps, status, interrupt and overrides of the panel block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam int BLINK = 4;
  logic        mclk, sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [5:0]  wb_adr_i, indicator_lamp, v, s;
  logic [3:0]  wb_sel_i, sel_v, button_pin, button_lamp, cfg, cur, val, pins;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          miscompares, n_checks, seed, i, lit, dark;

  panel_buttons u_panel_buttons (.mclk(mclk), .button_pin(button_pin));
  panel_button_lamp_control #(.BLINK_CYC(BLINK)) u_panel_button_lamp_control (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .button_pin(button_pin), .button_lamp(button_lamp),
    .indicator_lamp(indicator_lamp), .irq(irq));

  // Clock and overall watchdog
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  // Expected latched state after an override: set, OR, NOT-AND on alternate bits
  function automatic logic [3:0] ovr(input int op, input logic [3:0] c, d, m);
    logic [3:0] n;
    n = (op == 0) ? d : (op == 1) ? (c | d) : ~(c & d);
    return (n & m) | (c & ~m);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  // Count lit and dark cycles of one lamp group over two blink periods
  task automatic watch(input logic btn, input logic [5:0] on);
    lit = 0;
    dark = 0;
    repeat (4 * BLINK) begin
      @(posedge mclk);
      s = btn ? {2'b00, button_lamp} : indicator_lamp;
      if (s === on) lit++;
      else if (s === 6'h00) dark++;
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h34E0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    sel_v = 4'hF;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (i = 0; i < 14; i++) rchk("reset", 6'(4 * i), 32'h0);
    for (i = 0; i < 6; i++) begin
      cfg = 4'($random(seed));
      bus(1'b1, panel_pkg::OFS_BTN_CFG, {28'h0, cfg});
      rchk("cfg", panel_pkg::OFS_BTN_CFG, {28'h0, cfg});
    end
    sel_v = 4'hE;
    bus(1'b1, panel_pkg::OFS_BTN_CFG, 32'h0);
    sel_v = 4'hF;
    rchk("cfg_sel", panel_pkg::OFS_BTN_CFG, {28'h0, cfg});
    bus(1'b1, panel_pkg::OFS_LAMP_SEP, 32'h1);
    rchk("sep", panel_pkg::OFS_LAMP_SEP, 32'h1);
    bus(1'b1, 6'h3C, 32'hFF);
    rchk("unmapped", 6'h3C, 32'h0);
    $display("test registers done");
    v = 6'($random(seed)) | 6'h01;
    bus(1'b1, panel_pkg::OFS_IND_FL, 32'h0);
    bus(1'b1, panel_pkg::OFS_IND_ON, {26'h0, v});
    repeat (3) @(posedge mclk);
    `CHK("ind_on", v, indicator_lamp)
    bus(1'b1, panel_pkg::OFS_IND_FL, 32'h3F);
    watch(1'b0, v);
    `CHK("ind_blink", 1'b1, lit == 2 * BLINK && dark == 2 * BLINK)
    // Clock enable low freezes the blink phase and the lamps
    @(posedge mclk);
    clk_en <= 1'b0;
    repeat (2) @(posedge mclk);
    s = indicator_lamp;
    repeat (3 * BLINK) @(posedge mclk);
    `CHK("frozen", s, indicator_lamp)
    clk_en <= 1'b1;
    bus(1'b1, panel_pkg::OFS_IND_ON, 32'h0);
    watch(1'b0, 6'h3F);
    `CHK("ind_dark", 4 * BLINK, dark)
    $display("test indicators done");
    bus(1'b1, panel_pkg::OFS_BTN_CFG, 32'h0);
    bus(1'b1, panel_pkg::OFS_IRQ_ENABLE, 32'h0);
    pins = 4'($random(seed)) | 4'h2;
    u_panel_buttons.press(pins);
    repeat (5) @(posedge mclk);
    rchk("momentary", panel_pkg::OFS_BTN_STATUS, {28'h0, pins});
    u_panel_buttons.press(4'h0);
    repeat (5) @(posedge mclk);
    rchk("irq_status", panel_pkg::OFS_IRQ_STATUS, {28'h0, pins});
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, panel_pkg::OFS_IRQ_ENABLE, 32'hF);
    repeat (3) @(posedge mclk);
    `CHK("irq_raised", 1'b1, irq)
    bus(1'b1, panel_pkg::OFS_IRQ_CLEAR, 32'hF);
    repeat (3) @(posedge mclk);
    `CHK("irq_cleared", 1'b0, irq)
    $display("test status and interrupt done");
    val = 4'($random(seed));
    bus(1'b1, panel_pkg::OFS_BTN_LAMP_ON, {28'h0, val});
    repeat (3) @(posedge mclk);
    `CHK("btn_on", val, button_lamp)
    bus(1'b1, panel_pkg::OFS_LAMP_SEP, 32'h0);
    bus(1'b1, panel_pkg::OFS_BTN_LAMP_FL, 32'hF);
    watch(1'b1, 6'h0F);
    `CHK("btn_nosep", 4 * BLINK, dark)
    bus(1'b1, panel_pkg::OFS_LAMP_SEP, 32'h1);
    bus(1'b1, panel_pkg::OFS_BTN_LAMP_ON, 32'hF);
    watch(1'b1, 6'h0F);
    `CHK("btn_blink", 1'b1, lit == 2 * BLINK && dark == 2 * BLINK)
    bus(1'b1, panel_pkg::OFS_BTN_LAMP_FL, 32'h0);
    bus(1'b1, panel_pkg::OFS_BTN_LAMP_ON, 32'hF);
    $display("test button lamps done");
    cfg = 4'($random(seed)) | 4'h1;
    cur = 4'h0;
    bus(1'b1, panel_pkg::OFS_BTN_CFG, {28'h0, cfg});
    for (i = 0; i < 24; i++) begin
      val = 4'($random(seed));
      bus(1'b1, 6'(panel_pkg::OFS_OVR_SET + 4 * (i % 3)), {28'h0, val});
      cur = ovr(i % 3, cur, val, cfg);
      rchk("override", panel_pkg::OFS_BTN_STATUS, {28'h0, cur & cfg});
    end
    u_panel_buttons.press(4'h1);
    repeat (6) @(posedge mclk);
    u_panel_buttons.press(4'h0);
    repeat (6) @(posedge mclk);
    cur[0] = ~cur[0];
    rchk("toggle", panel_pkg::OFS_BTN_STATUS, {28'h0, cur & cfg});
    `CHK("alt_lamp", (cur & cfg) | ~cfg, button_lamp)
    $display("test overrides done");
    end_sim();
  end
endmodule

bind panel_button_lamp_control panel_properties #(.NB(NB), .NI(NI)) u_panel_properties (
  .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .button_pin(button_pin), .button_lamp(button_lamp),
  .indicator_lamp(indicator_lamp), .irq(irq));
